// ### trh_pkg.sv
// Shared constants and types for the transport reset handler.
// Assumes a single 200 MHz node clock and a 32-bit Wishbone register bus.
package trh_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ    = 200_000_000;
    localparam int T_BC_MS   = 25;             // Reset to beginning comm, ms
    localparam int T_WALK_MS = 125;            // Walk step timeout, ms
    localparam int T_HOLD_S  = 10;             // Configuring hold, s
    localparam int BC_CYC    = CLK_HZ / 1000 * T_BC_MS;
    localparam int WALK_CYC  = CLK_HZ / 1000 * T_WALK_MS;
    localparam int HOLD_CYC  = CLK_HZ * T_HOLD_S;
    localparam int DELIM_MIN = 200;            // Delimiters before a reset frame

    // ==========================================================
    // Per-port reset values
    localparam logic [7:0] Q1_RST  = 8'h01;
    localparam logic [7:0] Q2_RST  = 8'h04;
    localparam logic [7:0] ERP_RST = 8'h00;
    localparam logic [7:0] WARN_RST = 8'h0a;

    // ==========================================================
    // Register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_DROP = 8'h08;
    localparam int C_CFG   = 0;                // Node is web-configuring
    localparam int C_SOFT  = 1;                // Originate soft reset
    localparam int C_HARD  = 2;                // Originate hard reset
    localparam int C_RSVD  = 3;                // Originate reserved frame
    localparam int C_WALK  = 4;                // Start web reset walk
    localparam int C_INSVC = 5;                // Set in-service bit

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LS_DISABLED = 2'b00, LS_ENABLED = 2'b01, LS_READY = 2'b11, LS_CHECK = 2'b10
    } trh_link_t;
    typedef enum logic [1:0] {
        K_SOFT = 2'b00, K_RSVD = 2'b01, K_HARD = 2'b10
    } trh_kind_t;
    typedef enum logic [1:0] {
        NK_SINGLE = 2'b00, NK_DUAL = 2'b01, NK_SWITCH = 2'b10
    } trh_node_t;
    typedef enum logic [3:0] {
        WC_CLR_SELF = 4'h0, WC_DISABLE = 4'h1, WC_BEGIN = 4'h2, WC_MARK_SEL = 4'h3,
        WC_SETUP = 4'h4, WC_INQ = 4'h5, WC_SOFT = 4'h6, WC_HARD = 4'h7,
        WC_ADD = 4'h8, WC_FAR = 4'h9, WC_MARK_REP = 4'ha, WC_NEW_BASE = 4'hb,
        WC_CLR_TAB = 4'hc, WC_CONFIG = 4'hd, WC_REBUILD = 4'he, WC_NONE = 4'hf
    } trh_wcmd_t;
endpackage : trh_pkg

// ### trh_top.sv
// Transport reset handler: reset frame processing, reset frame origination
// and forwarding, power-on reset and the master's web reset walk.
// Assumes framing, link state machines and message transport live outside;
// they report events here as one-cycle pulses and obey the command pulses.
//
// Contract
// - Soft reset: self-check, clear in-service, ports Disabled and Privileged.
// - Soft reset initialises buffers, both frame indices and both value pools.
// - Soft reset clears all tables and drops pending unsolicited notices.
// - Per-port values load as 1, 4, 0, 0, 0 and 10.
// - Beginning communication starts within 25 ms of the soft reset frame.
// - Hard reset frame resets transport and clients like power-on.
// - Configuring node holds configuration 10 s or until rebuild notice.
// - Configuring node can originate soft, reserved and hard frames.
// - Reset frames bypass pacing, acknowledgement and sequence state.
// - Pending reset frame goes right after current frame, ahead of queue.
// - In Enabled, send at least 200 delimiters before a reset frame; here a frame still pending when another is sent follows it with none.
// - Reset frames may be sent in Enabled or Ready.
// - Reset frames recognised in any state with sync, buffers full or not.
// - Router keeps one stored reset frame, may drop further ones.
// - Stored frame held while output Disabled or Check.
// - Forwarding ignores output port in-service bit.
// - Power-on: ports to Wrap mode, then hard reset.
// - Walk prep: clear table with self, disable ports, clear bit, begin.
// - Select port, port setup, node inquiry with 125 ms; known ID skips.
// - Unknown node: soft reset, 125 ms for link-up, else hard reset.
// - Add node; dual advances, switch marks port; end when nothing left.
// - Finish: clear table, configure, send rebuild notice.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.

// ==========================================================
// Interval counter
module trh_tmr #(
    parameter int CYC = 100
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic arm_i,
    output logic      run_o,
    output logic      exp_o
);
    logic [31:0] cnt;

    // Load on arm restarts a running interval
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 32'h0;
        end else if (arm_i) begin
            cnt <= 32'(CYC);
        end else if (cnt != 32'h0) begin
            cnt <= cnt - 32'h1;
        end
    end

    assign run_o = (cnt != 32'h0);
    assign exp_o = (cnt == 32'h1) && !arm_i;
endmodule : trh_tmr

// ==========================================================
// Top level
module trh_top
    import trh_pkg::*;
#(
    parameter int NPORT    = 2,
    parameter int BC_CYC   = trh_pkg::BC_CYC,
    parameter int WALK_CYC = trh_pkg::WALK_CYC,
    parameter int HOLD_CYC = trh_pkg::HOLD_CYC
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Received reset frames
    input  wire logic                 rx_frame_i,
    input  wire trh_pkg::trh_kind_t   rx_kind_i,
    input  wire logic                 rx_sync_i,
    input  wire logic                 fwd_frame_i,
    input  wire trh_pkg::trh_kind_t   fwd_kind_i,
    // Transmitter of the output link
    input  wire trh_pkg::trh_link_t   link_state_i,
    input  wire logic                 tx_busy_i,
    input  wire logic                 char_tick_i,
    output logic                      tx_delim_o,
    output logic                      tx_preempt_o,
    output logic                      tx_send_o,
    output trh_pkg::trh_kind_t        tx_kind_o,
    output logic                      fwd_drop_o,
    // Node reset actions
    input  wire logic                 selfcheck_done_i,
    input  wire logic                 rebuild_notice_i,
    output logic                      wrap_mode_o,
    output logic                      hard_reset_o,
    output logic                      soft_clear_o,
    output logic                      selfcheck_go_o,
    output logic                      port_disable_o,
    output logic                      begin_comm_o,
    output logic                      in_service_o,
    output logic                      config_hold_o,
    // Per-port values, 8 bits per port except the single-bit echo select and extra detail flags
    output logic [8*NPORT-1:0]        first_credit_quota_o,
    output logic [8*NPORT-1:0]        second_credit_quota_o,
    output logic [NPORT-1:0]          echo_select_bit_o,
    output logic [NPORT-1:0]          extra_detail_bit_o,
    output logic [8*NPORT-1:0]        recovery_attempt_count_o,
    output logic [8*NPORT-1:0]        warning_trip_level_o,
    // Web reset walk
    input  wire logic                 unsel_avail_i,
    input  wire logic                 new_base_i,
    input  wire logic                 node_answer_i,
    input  wire logic                 id_known_i,
    input  wire logic                 link_up_i,
    input  wire trh_pkg::trh_node_t   node_kind_i,
    output logic                      walk_cmd_valid_o,
    output trh_pkg::trh_wcmd_t        walk_cmd_o
);
    import trh_pkg::*;

    // ==========================================================
    // Node reset sequencer
    typedef enum logic [2:0] {
        M_IDLE = 3'b000, M_WRAP = 3'b001, M_HARD = 3'b011, M_CLEAR = 3'b010,
        M_WAIT = 3'b110, M_BEGIN = 3'b111
    } trh_mstate_t;
    trh_mstate_t mstate, next_mstate;

    // Walk states and flags read by more than one section
    typedef enum logic [4:0] {
        W_IDLE = 5'h00, W_CLRS = 5'h01, W_DIS = 5'h03, W_BC = 5'h02, W_BASE = 5'h06,
        W_SEL = 5'h07, W_SETUP = 5'h05, W_INQ = 5'h04, W_INQW = 5'h0c, W_SOFT = 5'h0d,
        W_LUPW = 5'h0f, W_ADD = 5'h0e, W_KIND = 5'h0a, W_HARD = 5'h0b, W_MREP = 5'h09,
        W_FIN = 5'h08, W_CFG = 5'h18, W_RBLD = 5'h19, W_NEWB = 5'h1b
    } trh_wstate_t;
    trh_wstate_t wstate, next_wstate;
    trh_wcmd_t   wcmd;
    logic        cfg_node, tx_pend, store_full;

    logic rx_ok, acc_soft, acc_hard, t25_run, t25_exp, t10_run, t10_exp;

    // Recognition needs only sync; no buffer or pacing state is consulted
    assign rx_ok    = rx_frame_i && rx_sync_i;
    assign acc_hard = rx_ok && (rx_kind_i == K_HARD) && (mstate == M_IDLE);
    assign acc_soft = rx_ok && (rx_kind_i == K_SOFT) && (mstate == M_IDLE);

    always_comb begin
        next_mstate = mstate;
        case (mstate)
            M_IDLE: begin
                if (acc_hard) next_mstate = M_HARD;
                else if (acc_soft) next_mstate = M_CLEAR;
            end
            M_WRAP:  next_mstate = M_HARD;
            M_HARD:  next_mstate = M_CLEAR;
            M_CLEAR: next_mstate = M_WAIT;
            M_WAIT: begin
                if (selfcheck_done_i || t25_exp) next_mstate = M_BEGIN;
            end
            M_BEGIN: next_mstate = M_IDLE;
            default: next_mstate = M_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) mstate <= M_WRAP;
        else mstate <= next_mstate;
    end

    // Action pulses decode straight from the state
    assign hard_reset_o   = (mstate == M_HARD);
    assign soft_clear_o   = (mstate == M_CLEAR);
    assign selfcheck_go_o = soft_clear_o;
    assign port_disable_o = soft_clear_o || (wcmd == WC_DISABLE);
    assign begin_comm_o   = (mstate == M_BEGIN);

    // Interval counters on the node clock
    trh_tmr #(.CYC(BC_CYC)) u_t25 (
        .clk_i(clk_i), .rst_i(rst_i), .arm_i(soft_clear_o), .run_o(t25_run), .exp_o(t25_exp)
    );
    logic hold_arm;
    assign hold_arm = (acc_soft || acc_hard) && cfg_node;
    trh_tmr #(.CYC(HOLD_CYC)) u_t10 (
        .clk_i(clk_i), .rst_i(rst_i), .arm_i(hold_arm), .run_o(t10_run), .exp_o(t10_exp)
    );

    // Wrap mode from power-on until communication begins
    always_ff @(posedge clk_i) begin
        if (rst_i) wrap_mode_o <= 1'b1;
        else if (begin_comm_o) wrap_mode_o <= 1'b0;
    end

    // Configuration hold; a new arm wins over an ending event
    always_ff @(posedge clk_i) begin
        if (rst_i) config_hold_o <= 1'b0;
        else if (hold_arm) config_hold_o <= 1'b1;
        else if (t10_exp || rebuild_notice_i) config_hold_o <= 1'b0;
    end

    // Per-port values, reloaded by every soft clear
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            always_ff @(posedge clk_i) begin
                if (rst_i || soft_clear_o) begin
                    first_credit_quota_o[8*gp +: 8]     <= Q1_RST;
                    second_credit_quota_o[8*gp +: 8]    <= Q2_RST;
                    echo_select_bit_o[gp]               <= 1'b0;
                    extra_detail_bit_o[gp]              <= 1'b0;
                    recovery_attempt_count_o[8*gp +: 8] <= ERP_RST;
                    warning_trip_level_o[8*gp +: 8]     <= WARN_RST;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Register bus
    logic       wr_en, rd_ctrl, rd_stat, rd_drop;
    logic       own_req;
    trh_kind_t  own_req_kind;
    logic [7:0] drop_cnt;

    assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_ctrl = (wb_adr_i == A_CTRL);
    assign rd_stat = (wb_adr_i == A_STAT);
    assign rd_drop = (wb_adr_i == A_DROP);
    // Origination pulses; configuring nodes only
    assign own_req = wr_en && rd_ctrl && cfg_node
                     && (wb_dat_i[C_SOFT] || wb_dat_i[C_HARD] || wb_dat_i[C_RSVD]);
    assign own_req_kind = wb_dat_i[C_HARD] ? K_HARD : (wb_dat_i[C_RSVD] ? K_RSVD : K_SOFT);

    // Single-wait answer; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_ctrl ? {31'h0, cfg_node} :
                        rd_stat ? {19'h0, wstate, mstate, tx_pend, store_full,
                                   config_hold_o, in_service_o, wrap_mode_o} :
                        rd_drop ? {24'h0, drop_cnt} : 32'h0;
        end
    end

    // Configuring flag and in-service bit; hardware clear wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_node     <= 1'b0;
            in_service_o <= 1'b0;
        end else begin
            if (wr_en && rd_ctrl) cfg_node <= wb_dat_i[C_CFG];
            if (soft_clear_o || wcmd == WC_DISABLE) in_service_o <= 1'b0;
            else if (wr_en && rd_ctrl && wb_dat_i[C_INSVC]) in_service_o <= 1'b1;
        end
    end

    // ==========================================================
    // Reset frame transmit path and router store
    logic      own_pend, link_ok, gate_ok, store_rel, send_go;
    trh_kind_t own_kind, store_kind;
    logic [7:0] delim_cnt;

    assign tx_pend   = own_pend || store_full;
    // In-service bit is deliberately not part of the gate
    assign link_ok   = (link_state_i == LS_ENABLED) || (link_state_i == LS_READY);
    assign gate_ok   = (link_state_i == LS_READY) || (delim_cnt >= 8'(DELIM_MIN));
    // A store-sourced send frees the slot at the same edge a new frame may land
    assign send_go   = tx_pend && link_ok && gate_ok && !tx_busy_i && !tx_send_o;
    assign store_rel = send_go && !own_pend;
    assign tx_delim_o   = tx_pend && (link_state_i == LS_ENABLED) && !gate_ok;
    assign tx_preempt_o = tx_pend;
    assign fwd_drop_o   = fwd_frame_i && store_full && !store_rel;

    // Own request goes first; a sent frame clears its source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_pend   <= 1'b0;
            own_kind   <= K_SOFT;
            store_full <= 1'b0;
            store_kind <= K_SOFT;
            tx_send_o  <= 1'b0;
            tx_kind_o  <= K_SOFT;
            drop_cnt   <= 8'h0;
        end else begin
            tx_send_o  <= 1'b0;
            if (send_go) begin
                tx_send_o <= 1'b1;
                tx_kind_o <= own_pend ? own_kind : store_kind;
                if (own_pend) own_pend <= 1'b0;
                else store_full <= 1'b0;
            end
            if (own_req) begin
                own_pend <= 1'b1;
                own_kind <= own_req_kind;
            end
            if (fwd_frame_i && (!store_full || store_rel)) begin
                store_full <= 1'b1;
                store_kind <= fwd_kind_i;
            end
            if (fwd_drop_o) drop_cnt <= drop_cnt + 8'h1;
        end
    end

    // Delimiter count restarts whenever nothing waits in Enabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_pend || link_state_i != LS_ENABLED) delim_cnt <= 8'h0;
        else if (char_tick_i && !gate_ok) delim_cnt <= delim_cnt + 8'h1;
    end

    // ==========================================================
    // Web reset walk
    logic        t125_run, t125_exp, t125_arm;

    assign t125_arm = (wstate == W_INQ) || (wstate == W_SOFT);
    trh_tmr #(.CYC(WALK_CYC)) u_t125 (
        .clk_i(clk_i), .rst_i(rst_i), .arm_i(t125_arm), .run_o(t125_run), .exp_o(t125_exp)
    );

    always_comb begin
        next_wstate = wstate;
        case (wstate)
            W_IDLE:  if (wr_en && rd_ctrl && wb_dat_i[C_WALK]) next_wstate = W_CLRS;
            W_CLRS:  next_wstate = W_DIS;
            W_DIS:   next_wstate = W_BC;
            W_BC:    next_wstate = W_BASE;
            W_BASE: begin
                if (unsel_avail_i) next_wstate = W_SEL;
                else if (new_base_i) next_wstate = W_NEWB;
                else next_wstate = W_FIN;
            end
            W_NEWB:  next_wstate = W_BASE;
            W_SEL:   next_wstate = W_SETUP;
            W_SETUP: next_wstate = W_INQ;
            W_INQ:   next_wstate = W_INQW;
            W_INQW: begin
                if (node_answer_i) next_wstate = id_known_i ? W_MREP : W_SOFT;
                else if (t125_exp) next_wstate = W_SOFT;
            end
            W_SOFT:  next_wstate = W_LUPW;
            W_LUPW: begin
                if (link_up_i) next_wstate = W_ADD;
                else if (t125_exp) next_wstate = W_HARD;
            end
            W_HARD:  next_wstate = W_BASE;
            W_ADD:   next_wstate = W_KIND;
            W_KIND:  next_wstate = (node_kind_i == NK_DUAL) ? W_SETUP : W_BASE;
            W_MREP:  next_wstate = W_BASE;
            W_FIN:   next_wstate = W_CFG;
            W_CFG:   next_wstate = W_RBLD;
            W_RBLD:  next_wstate = W_IDLE;
            default: next_wstate = W_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) wstate <= W_IDLE;
        else wstate <= next_wstate;
    end

    // Command for the message layer, one per step state
    always_comb begin
        case (wstate)
            W_CLRS:  wcmd = WC_CLR_SELF;
            W_DIS:   wcmd = WC_DISABLE;
            W_BC:    wcmd = WC_BEGIN;
            W_SEL:   wcmd = WC_MARK_SEL;
            W_SETUP: wcmd = WC_SETUP;
            W_INQ:   wcmd = WC_INQ;
            W_SOFT:  wcmd = WC_SOFT;
            W_HARD:  wcmd = WC_HARD;
            W_ADD:   wcmd = WC_ADD;
            W_KIND:  wcmd = (node_kind_i == NK_DUAL) ? WC_FAR :
                            (node_kind_i == NK_SWITCH) ? WC_MARK_REP : WC_NONE;
            W_MREP:  wcmd = WC_MARK_REP;
            W_NEWB:  wcmd = WC_NEW_BASE;
            W_FIN:   wcmd = WC_CLR_TAB;
            W_CFG:   wcmd = WC_CONFIG;
            W_RBLD:  wcmd = WC_REBUILD;
            default: wcmd = WC_NONE;
        endcase
    end
    assign walk_cmd_o       = wcmd;
    assign walk_cmd_valid_o = (wcmd != WC_NONE);

    // ==========================================================
    // Checks
    logic [31:0] bc_age;
    always_ff @(posedge clk_i) begin
        if (rst_i || begin_comm_o || mstate == M_IDLE) bc_age <= 32'h0;
        else bc_age <= bc_age + 32'h1;
    end

    property p_por;
        @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> wrap_mode_o ##1 hard_reset_o;
    endproperty
    a_por: assert property (p_por) else $error("power-on not wrap then hard");

    property p_hard;
        @(posedge clk_i) disable iff (rst_i) hard_reset_o |=> soft_clear_o && port_disable_o;
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset skipped clear");

    property p_vals;
        @(posedge clk_i) disable iff (rst_i) soft_clear_o |=>
            first_credit_quota_o[7:0] == 8'h01 && second_credit_quota_o[7:0] == 8'h04
            && warning_trip_level_o[7:0] == 8'h0a && !echo_select_bit_o[0];
    endproperty
    a_vals: assert property (p_vals) else $error("port values wrong");

    property p_bc;
        @(posedge clk_i) disable iff (rst_i) bc_age <= 32'(BC_CYC) + 32'h3;
    endproperty
    a_bc: assert property (p_bc) else $error("beginning comm late");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i) $rose(config_hold_o) |-> $past(rx_ok && cfg_node);
    endproperty
    a_hold: assert property (p_hold) else $error("hold without reset frame");

    property p_txgate;
        @(posedge clk_i) disable iff (rst_i)
            tx_send_o |-> $past(!tx_busy_i && link_ok && gate_ok);
    endproperty
    a_txgate: assert property (p_txgate) else $error("reset frame sent too early");

    property p_drop;
        @(posedge clk_i) disable iff (rst_i)
            fwd_frame_i && !store_full |-> !fwd_drop_o ##1 store_full;
    endproperty
    a_drop: assert property (p_drop) else $error("first frame not stored");

    property p_walkto;
        @(posedge clk_i) disable iff (rst_i)
            wstate == W_LUPW && t125_exp && !link_up_i |=> walk_cmd_o == WC_HARD;
    endproperty
    a_walkto: assert property (p_walkto) else $error("no hard reset on timeout");

    property p_inq;
        @(posedge clk_i) disable iff (rst_i) walk_cmd_o == WC_INQ |=> t125_run;
    endproperty
    a_inq: assert property (p_inq) else $error("inquiry timer not armed");
endmodule : trh_top

// ### trh_far.sv
// Far-side link transmitter stand-in.
// Assumes one node clock; a sent frame keeps the link busy a while.
// ==========================================
module trh_far (
    // Link side
    input  wire logic clk_i,
    input  wire logic delim_i,
    input  wire logic send_i,
    output logic      busy_o,
    output logic      tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    initial busy_o = 0;
    initial tick_o = 0;
    // No pacing or ack: the frame just occupies the line, busy for 2 to 5 cycles
    always @(posedge clk_i) begin
        tick_o <= delim_i;
        left   <= send_i ? 3 + $urandom % 4 : (left > 0 ? left - 1 : 0);
        busy_o <= left > 1;
    end
endmodule // trh_far

// ### testbench.sv
// Self-checking bench for trh_top, short timers.
// Assumes trh_far drives the output link.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import trh_pkg::*;
    // ==========================================
    // Signals
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, rxf = 0, fwf = 0, scd = 0, rbn = 0, z = 0;
    logic        ua = 0, sy = 1, ins, sg, tp;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0, rd, dat;
    logic        ack, dl, snd, drp, wrp, hr, sc, pd, bc, ch, wv, busy, tick;
    logic [15:0] q1, q2, ec, wl;
    logic [1:0]  es, ed;
    trh_kind_t   rxk = K_SOFT, tk;
    trh_kind_t   kt[3] = '{K_SOFT, K_HARD, K_RSVD};
    trh_link_t   ls = LS_READY;
    trh_wcmd_t   wc, wq[$];
    trh_wcmd_t   wx[6] = '{WC_CLR_SELF, WC_DISABLE, WC_BEGIN, WC_CLR_TAB, WC_CONFIG, WC_REBUILD};
    trh_wcmd_t   wy[11] = '{WC_CLR_SELF, WC_DISABLE, WC_BEGIN, WC_MARK_SEL, WC_SETUP, WC_INQ,
                            WC_SOFT, WC_HARD, WC_CLR_TAB, WC_CONFIG, WC_REBUILD};
    int err_total = 0, samples_checked = 0, i, n;
    always #2.5 clk_i = ~clk_i;
    // Walk commands collected for the model
    always @(posedge clk_i) if (wv === 1'b1) wq.push_back(wc);
    trh_top #(.BC_CYC(50), .WALK_CYC(100), .HOLD_CYC(200)) i_trh_top (
        .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .rx_frame_i(rxf),
        .rx_kind_i(rxk), .rx_sync_i(sy), .fwd_frame_i(fwf), .fwd_kind_i(rxk),
        .link_state_i(ls), .tx_busy_i(busy), .char_tick_i(tick), .tx_delim_o(dl),
        .tx_preempt_o(tp), .tx_send_o(snd), .tx_kind_o(tk), .fwd_drop_o(drp),
        .selfcheck_done_i(scd), .rebuild_notice_i(rbn), .wrap_mode_o(wrp),
        .hard_reset_o(hr), .soft_clear_o(sc), .selfcheck_go_o(sg), .port_disable_o(pd),
        .begin_comm_o(bc), .in_service_o(ins), .config_hold_o(ch), .first_credit_quota_o(q1),
        .second_credit_quota_o(q2), .echo_select_bit_o(es), .extra_detail_bit_o(ed),
        .recovery_attempt_count_o(ec), .warning_trip_level_o(wl), .unsel_avail_i(ua),
        .new_base_i(z), .node_answer_i(z), .id_known_i(z), .link_up_i(z),
        .node_kind_i(NK_SINGLE), .walk_cmd_valid_o(wv), .walk_cmd_o(wc));
    trh_far i_trh_far (.clk_i, .delim_i(dl), .send_i(snd), .busy_o(busy), .tick_o(tick));
    // ==========================================
    // Tasks
    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // Bounded wait for a design pulse, sampled mid-cycle
    task automatic waitc(ref logic s, input int lim);
        for (n = 0; n < lim && s !== 1'b1; n++) @(negedge clk_i);
        chk("wait", 1, s);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        we  <= w;
        adr <= a;
        wd  <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat;
        cyc <= 0;
        chk("ack", 1, ack);
    endtask
    task close_out;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h9569f3aa));
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        waitc(hr, 5);
        chk("wrap", 1, wrp);
        waitc(bc, 60);
        for (i = 0; i < 2; i++) begin
            chk("quota", 32'h0104, {q1[8*i+:8], q2[8*i+:8]});
            chk("level", 32'h000a, {es[i], ed[i], ec[8*i+:8], wl[8*i+:8]});
        end
        wb(1, 8'h0c, $urandom);
        wb(0, 8'h0c, 0);
        chk("unmapped", 0, rd);
        // Enabled link: delimiters must precede the frame
        ls <= LS_ENABLED;
        // Origination only counts once the configuring flag is already set
        wb(1, A_CTRL, 32'h1);
        wb(1, A_CTRL, 32'h3);
        chk("preempt", 1, tp);
        i = 0;
        for (n = 0; n < 400 && snd !== 1'b1; n++) @(negedge clk_i) i += tick;
        chk("send", 1, snd);
        chk("delims", 1, i >= DELIM_MIN);
        chk("kind", K_SOFT, tk);
        @(posedge clk_i);
        ls <= LS_READY;
        foreach (kt[k]) begin
            wb(1, A_CTRL, 32'h1 | (32'h2 << k));
            waitc(snd, 20);
            chk("kind", kt[k], tk);
        end
        // Forwarding into a Disabled port: stored, second dropped
        @(posedge clk_i);
        ls  <= LS_DISABLED;
        rxk <= K_HARD;
        fwf <= 1;
        @(negedge clk_i);
        @(negedge clk_i);
        chk("drop", 1, drp);
        @(posedge clk_i);
        fwf <= 0;
        i = 0;
        repeat (20) @(negedge clk_i) i += snd;
        chk("held", 0, i);
        @(posedge clk_i);
        ls <= LS_READY;
        waitc(snd, 20);
        chk("kind", K_HARD, tk);
        wb(1, A_CTRL, 32'h21);
        chk("insvc", 1, ins);
        // A frame without character sync must be ignored
        @(posedge clk_i);
        {rxf, sy} <= 2'b10;
        @(posedge clk_i);
        {rxf, sy} <= 2'b01;
        @(negedge clk_i);
        chk("nosync", 0, {hr, sc});
        @(posedge clk_i);
        rxk <= K_SOFT;
        rxf <= 1;
        @(posedge clk_i);
        rxf <= 0;
        @(negedge clk_i);
        chk("clear", 7, {sc, pd, sg});
        chk("hold", 1, ch);
        @(posedge clk_i);
        {scd, rbn} <= 2'b11;
        @(posedge clk_i);
        {scd, rbn} <= 2'b00;
        @(negedge clk_i);
        chk("hold", 0, ch);
        chk("insvc", 0, ins);
        waitc(bc, 10);
        wq.delete();
        wb(1, A_CTRL, 32'h11);
        for (n = 0; n < 80 && wq.size() < 6; n++) @(negedge clk_i);
        foreach (wx[k]) chk("walk", wx[k], wq[k]);
        // One base port, silent node: inquiry and link-up both time out
        wq.delete();
        @(posedge clk_i);
        ua <= 1;
        wb(1, A_CTRL, 32'h11);
        repeat (8) @(posedge clk_i);
        ua <= 0;
        for (n = 0; n < 400 && wq.size() < 11; n++) @(negedge clk_i);
        foreach (wy[k]) chk("walk", wy[k], wq[k]);
        close_out();
    end
endmodule // testbench
